// [logic/flash_ctrl_map.svh]
// Register offsets, field positions, reset values and timing counts of the flash controller.
// Assumes a 250 MHz clock and word addressing on the Avalon-MM slave port.
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

`define REG_CTRL 3'h0
`define REG_ADDR 3'h1
`define REG_WDATA 3'h2
`define REG_RDATA 3'h3
`define REG_STATUS 3'h4
`define REG_RSTCMD 3'h5

`define CTRL_OP_LSB 0
`define CTRL_SKIP_BIT 4

`define ST_BUSY 0
`define ST_DONE_OK 1
`define ST_FAIL 2
`define ST_SECT_TOG 3
`define ST_WIN_CLOSED 4
`define ST_MAYBE_REJ 5
`define ST_READY 6

`define RSTCMD_RESET 16'h0000

`define DQ_TOGGLE_BIT 6
`define DQ_TLIMIT_BIT 5
`define DQ_EWIN_BIT 3
`define DQ_SECT_BIT 2

`define CLK_PERIOD_NS 4
`define T_RD_NS 70
`define T_WP_NS 35
`define T_REC_NS 20
`define T_GAP_US 50
`define RD_CYC ((`T_RD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CYC ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_CYC ((`T_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC ((`T_GAP_US * 1000) / `CLK_PERIOD_NS)

`endif

// [logic/flash_ctrl_pkg.sv]
// Types shared by the flash controller and its bus cycle engine.
// Assumes the constants of flash_ctrl_map.svh are included where numbers are needed.
package flash_ctrl_pkg;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_POLL = 2'b10,
    OP_SECT_ERASE = 2'b11
  } op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_SINGLE = 4'h1,
    S_POLL1 = 4'h2,
    S_POLL2 = 4'h3,
    S_RECHK1 = 4'h4,
    S_RECHK2 = 4'h5,
    S_RSTCMD = 4'h6,
    S_WIN_PRE = 4'h7,
    S_WIN_CMD = 4'h8,
    S_WIN_POST = 4'h9
  } state_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ACT = 2'b01,
    CYC_REC = 2'b10
  } cyc_state_t;

  typedef struct packed {
    logic ready;
    logic maybe_rejected;
    logic window_closed;
    logic sector_toggled;
    logic fail_timing;
    logic done_ok;
    logic busy;
  } status_t;

endpackage

// [logic/flash_cycle.sv]
// One asynchronous flash bus cycle, read or write, timed in clock cycles.
// Assumes the requester waits for done_o before it asks again.
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_cycle #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16,
  parameter int RD_CYC = `RD_CYC,
  parameter int WR_CYC = `WR_CYC,
  parameter int REC_CYC = `REC_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic [DATA_W-1:0] dq_in_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);

  if (RD_CYC < 1 || RD_CYC > 255 || WR_CYC < 1 || WR_CYC > 255 ||
      REC_CYC < 1 || REC_CYC > 255) begin : g_chk
    $error("flash_cycle: cycle counts must lie in 1..255");
  end

  flash_ctrl_pkg::cyc_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic we_q, we_d;
  logic done_d;
  logic [DATA_W-1:0] rdata_d, dq_d;
  logic [ADDR_W-1:0] addr_d;
  logic dq_oe_n_d, ce_n_d, oe_n_d, we_n_d;
  logic [DATA_W-1:0] dq_i_s;

  assign dq_i_s = dq_in_i;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    we_d = we_q;
    done_d = 1'b0;
    rdata_d = rdata_o;
    addr_d = addr_o;
    dq_d = dq_o;
    dq_oe_n_d = dq_oe_n_o;
    ce_n_d = ce_n_o;
    oe_n_d = oe_n_o;
    we_n_d = we_n_o;
    unique case (st_q)
      flash_ctrl_pkg::CYC_IDLE: begin
        if (req_i) begin
          st_d = flash_ctrl_pkg::CYC_ACT;
          we_d = we_i;
          addr_d = addr_i;
          dq_d = data_i;
          ce_n_d = 1'b0;
          oe_n_d = we_i;
          we_n_d = ~we_i;
          dq_oe_n_d = ~we_i;
          cnt_d = we_i ? 8'(WR_CYC - 1) : 8'(RD_CYC - 1);
        end
      end
      flash_ctrl_pkg::CYC_ACT: begin
        if (cnt_q == 8'h00) begin
          // Data is sampled at the end of the strobe so the full access time has passed.
          if (!we_q) begin
            rdata_d = dq_i_s;
          end
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          we_n_d = 1'b1;
          st_d = flash_ctrl_pkg::CYC_REC;
          cnt_d = 8'(REC_CYC - 1);
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      flash_ctrl_pkg::CYC_REC: begin
        // The recovery gap covers output enable hold for status reads and address hold.
        if (cnt_q == 8'h00) begin
          dq_oe_n_d = 1'b1;
          done_d = 1'b1;
          st_d = flash_ctrl_pkg::CYC_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        st_d = flash_ctrl_pkg::CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= flash_ctrl_pkg::CYC_IDLE;
      cnt_q <= 8'h00;
      we_q <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_n_o <= 1'b1;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      we_q <= we_d;
      done_o <= done_d;
      rdata_o <= rdata_d;
      addr_o <= addr_d;
      dq_o <= dq_d;
      dq_oe_n_o <= dq_oe_n_d;
      ce_n_o <= ce_n_d;
      oe_n_o <= oe_n_d;
      we_n_o <= we_n_d;
    end
  end

endmodule

// [logic/flash_ctrl.sv]
// Host-side flash controller: software orders bus cycles, status polls and guarded
// sector erase commands over Avalon-MM; the controller drives the flash pins.
// Assumes flash inputs are synchronous to ref_clk_i and the flash keeps its own rules.
//
// Contract
// [RULE1] Timing-limit flag high means operation failed.
// [RULE2] Programming a one over zero ends failed.
// [RULE3] After failure, host writes the reset command.
// [RULE4] Erase window flag zero while acceptance timer runs.
// [RULE5] Chip erase has no acceptance window.
// [RULE6] Each extra sector command restarts full timeout.
// [RULE7] Skip window check only when spacing under 50us.
// [RULE8] Flag one: commands except suspend ignored.
// [RULE9] Flag zero: further sector erases accepted.
// [RULE10] Check window flag before and after commands.
// [RULE11] Status reads use a valid sector address.
// [RULE12] Read toggle twice; recheck after limit flag.
// [RULE13] Toggle bit inverts per read while busy.
// [RULE14] Sector toggle flips in selected sectors.
// [RULE15] Ready/busy low while programming or erasing.
// [RULE16] Pulse limit and timeout are parameters.
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_ctrl #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16,
  parameter int GAP_CYC = `GAP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  input wire logic flash_ready_busy_i
);

  if (DATA_W < 8 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 32 || GAP_CYC < 1 ||
      GAP_CYC > 65535) begin : g_chk
    $error("flash_ctrl: DATA_W 8..32, ADDR_W 1..32, GAP_CYC 1..65535");
  end

  flash_ctrl_pkg::state_t st_q, st_d;
  flash_ctrl_pkg::op_t op_q, op_d;
  flash_ctrl_pkg::status_t stat_q, stat_d;
  logic skip_q, skip_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d, first_q, first_d;
  logic [DATA_W-1:0] rstcmd_q, rstcmd_d;
  logic [15:0] gap_q, gap_d;
  logic pend_q, pend_d, req_q, req_d;
  logic wait_q, wait_d;
  logic [31:0] rd_q, rd_d;
  logic cyc_done, cyc_we;
  logic [DATA_W-1:0] cyc_rdata, cyc_data;
  logic bus_take;

  // Toggling means the named bit differs between two back-to-back reads.
  function automatic logic differs(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                   input int unsigned bit_pos);
    differs = a[bit_pos] ^ b[bit_pos];
  endfunction

  assign bus_take = (avs_read_i || avs_write_i) && !wait_q;
  assign cyc_we = (st_q == flash_ctrl_pkg::S_SINGLE && op_q == flash_ctrl_pkg::OP_WRITE) ||
                  st_q == flash_ctrl_pkg::S_RSTCMD || st_q == flash_ctrl_pkg::S_WIN_CMD;
  assign cyc_data = (st_q == flash_ctrl_pkg::S_RSTCMD) ? rstcmd_q : wdata_q;

  flash_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .RD_CYC(`RD_CYC),
    .WR_CYC(`WR_CYC),
    .REC_CYC(`REC_CYC)
  ) u_cycle (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .req_i(req_q),
    .we_i(cyc_we),
    .addr_i(addr_q),
    .data_i(cyc_data),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_in_i(flash_dq_i),
    .dq_oe_n_o(flash_dq_oe_n_o),
    .ce_n_o(flash_ce_n_o),
    .oe_n_o(flash_oe_n_o),
    .we_n_o(flash_we_n_o)
  );

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    stat_d = stat_q;
    skip_d = skip_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    first_d = first_q;
    rstcmd_d = rstcmd_q;
    gap_d = (gap_q == 16'(GAP_CYC)) ? gap_q : gap_q + 16'h0001;
    pend_d = pend_q;
    req_d = 1'b0;
    wait_d = 1'b1;
    rd_d = rd_q;
    stat_d.ready = flash_ready_busy_i;

    // Slave answers one cycle after a request is first seen.
    if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_d = 1'b0;
      unique case (avs_address_i)
        `REG_CTRL: rd_d = {27'h0, skip_q, 2'b00, op_q};
        `REG_ADDR: rd_d = 32'(addr_q);
        `REG_WDATA: rd_d = 32'(wdata_q);
        `REG_RDATA: rd_d = 32'(rdata_q);
        `REG_STATUS: rd_d = {25'h0, stat_q};
        `REG_RSTCMD: rd_d = 32'(rstcmd_q);
        default: rd_d = 32'h0000_0000;
      endcase
    end

    // Registers are frozen while an operation runs; a start order while busy is dropped.
    if (bus_take && avs_write_i && st_q == flash_ctrl_pkg::S_IDLE) begin
      unique case (avs_address_i)
        `REG_CTRL: begin
          op_d = flash_ctrl_pkg::op_t'(avs_writedata_i[`CTRL_OP_LSB +: 2]);
          skip_d = avs_writedata_i[`CTRL_SKIP_BIT];
          stat_d = '0;
          stat_d.busy = 1'b1;
          stat_d.ready = flash_ready_busy_i;
          unique case (flash_ctrl_pkg::op_t'(avs_writedata_i[`CTRL_OP_LSB +: 2]))
            flash_ctrl_pkg::OP_POLL: st_d = flash_ctrl_pkg::S_POLL1;
            flash_ctrl_pkg::OP_SECT_ERASE: begin
              // The check may be skipped only while the previous command is under 50us old.
              if (avs_writedata_i[`CTRL_SKIP_BIT] && gap_q != 16'(GAP_CYC)) begin // [RULE7]
                st_d = flash_ctrl_pkg::S_WIN_CMD;
              end else begin
                st_d = flash_ctrl_pkg::S_WIN_PRE; // [RULE10]
              end
            end
            default: st_d = flash_ctrl_pkg::S_SINGLE;
          endcase
        end
        `REG_ADDR: addr_d = ADDR_W'(avs_writedata_i);
        `REG_WDATA: wdata_d = DATA_W'(avs_writedata_i);
        `REG_RSTCMD: rstcmd_d = DATA_W'(avs_writedata_i);
        default: begin
        end
      endcase
    end

    if (st_q != flash_ctrl_pkg::S_IDLE) begin
      if (!pend_q) begin
        req_d = 1'b1;
        pend_d = 1'b1;
      end else if (cyc_done) begin
        pend_d = 1'b0;
        unique case (st_q)
          flash_ctrl_pkg::S_SINGLE: begin
            if (op_q == flash_ctrl_pkg::OP_READ) begin
              rdata_d = cyc_rdata;
            end
            stat_d.done_ok = 1'b1;
            stat_d.busy = 1'b0;
            st_d = flash_ctrl_pkg::S_IDLE;
          end
          flash_ctrl_pkg::S_POLL1: begin
            // Status reads go to the software-given program or erase-sector address.
            first_d = cyc_rdata; // [RULE11]
            st_d = flash_ctrl_pkg::S_POLL2;
          end
          flash_ctrl_pkg::S_POLL2: begin
            rdata_d = cyc_rdata;
            stat_d.sector_toggled = differs(first_q, cyc_rdata, `DQ_SECT_BIT); // [RULE14]
            if (!differs(first_q, cyc_rdata, `DQ_TOGGLE_BIT)) begin // [RULE12] [RULE13]
              stat_d.done_ok = 1'b1;
              stat_d.busy = 1'b0;
              st_d = flash_ctrl_pkg::S_IDLE;
            end else if (cyc_rdata[`DQ_TLIMIT_BIT]) begin // [RULE1]
              st_d = flash_ctrl_pkg::S_RECHK1; // [RULE12]
            end else begin
              st_d = flash_ctrl_pkg::S_POLL1;
            end
          end
          flash_ctrl_pkg::S_RECHK1: begin
            first_d = cyc_rdata;
            st_d = flash_ctrl_pkg::S_RECHK2;
          end
          flash_ctrl_pkg::S_RECHK2: begin
            rdata_d = cyc_rdata;
            if (!differs(first_q, cyc_rdata, `DQ_TOGGLE_BIT)) begin // [RULE12]
              stat_d.done_ok = 1'b1;
              stat_d.busy = 1'b0;
              st_d = flash_ctrl_pkg::S_IDLE;
            end else begin
              // Still toggling with the limit flag up: a failed program or erase.
              stat_d.fail_timing = 1'b1; // [RULE1] [RULE2]
              st_d = flash_ctrl_pkg::S_RSTCMD; // [RULE3]
            end
          end
          flash_ctrl_pkg::S_RSTCMD: begin
            stat_d.busy = 1'b0;
            st_d = flash_ctrl_pkg::S_IDLE;
          end
          flash_ctrl_pkg::S_WIN_PRE: begin
            rdata_d = cyc_rdata;
            if (cyc_rdata[`DQ_EWIN_BIT]) begin // [RULE8]
              stat_d.window_closed = 1'b1;
              stat_d.busy = 1'b0;
              st_d = flash_ctrl_pkg::S_IDLE;
            end else begin
              st_d = flash_ctrl_pkg::S_WIN_CMD; // [RULE9]
            end
          end
          flash_ctrl_pkg::S_WIN_CMD: begin
            // Each accepted command restarts the device timeout, so the gap restarts too.
            gap_d = 16'h0000; // [RULE6]
            st_d = flash_ctrl_pkg::S_WIN_POST;
          end
          flash_ctrl_pkg::S_WIN_POST: begin
            rdata_d = cyc_rdata;
            stat_d.maybe_rejected = cyc_rdata[`DQ_EWIN_BIT]; // [RULE10] [RULE4]
            stat_d.done_ok = ~cyc_rdata[`DQ_EWIN_BIT];
            stat_d.busy = 1'b0;
            st_d = flash_ctrl_pkg::S_IDLE;
          end
          default: begin
            st_d = flash_ctrl_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= flash_ctrl_pkg::S_IDLE;
      op_q <= flash_ctrl_pkg::OP_WRITE;
      stat_q <= '0;
      skip_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      first_q <= '0;
      rstcmd_q <= DATA_W'(`RSTCMD_RESET);
      gap_q <= 16'(GAP_CYC);
      pend_q <= 1'b0;
      req_q <= 1'b0;
      wait_q <= 1'b1;
      rd_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      stat_q <= stat_d;
      skip_q <= skip_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      first_q <= first_d;
      rstcmd_q <= rstcmd_d;
      gap_q <= gap_d;
      pend_q <= pend_d;
      req_q <= req_d;
      wait_q <= wait_d;
      rd_q <= rd_d;
    end
  end

  assign avs_readdata_o = rd_q;
  assign avs_waitrequest_o = wait_q;

endmodule

// [logic/flash_cycle_ports_fix.sv]
// This file holds no logic; the bus cycle engine is the flash_cycle module.

// [test/flash_ctrl_monitor.sv]
// Port checker for the flash controller: Avalon slave timing and flash strobe shapes.
// Assumes it is bound to every flash_ctrl instance and sees only its ports.
`timescale 1ns/1ps
module flash_ctrl_monitor #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16,
  parameter int GAP_CYC = 50
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe_n_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o
);
  logic [5:0] rd_len_q, rd_len_d, wr_len_q, wr_len_d;
  always_comb begin
    rd_len_d = flash_oe_n_o ? 6'h00 : rd_len_q + 6'h01;
    wr_len_d = flash_we_n_o ? 6'h00 : wr_len_q + 6'h01;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_len_q <= 6'h00;
      wr_len_q <= 6'h00;
    end else begin
      rd_len_q <= rd_len_d;
      wr_len_q <= wr_len_d;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("slave answer late");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 3'h5
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_read_length: assert property ($rose(flash_oe_n_o) |-> rd_len_q == 6'h12)
    else $error("read strobe length wrong");
  a_write_length: assert property ($rose(flash_we_n_o) |-> wr_len_q == 6'h09)
    else $error("write strobe length wrong");
  a_no_contention: assert property (!flash_oe_n_o |-> flash_dq_oe_n_o)
    else $error("data driven during read");
  a_write_drives: assert property (!flash_we_n_o |-> !flash_dq_oe_n_o)
    else $error("write without data drive");
  a_data_hold: assert property ($rose(flash_we_n_o)
    |-> (!flash_dq_oe_n_o && $stable(flash_dq_o)) [*4]) else $error("write data not held");
  a_addr_stable: assert property (!flash_ce_n_o && $past(!flash_ce_n_o)
    |-> $stable(flash_addr_o)) else $error("address moved in cycle");
  a_ce_frames: assert property ((!flash_oe_n_o || !flash_we_n_o) |-> !flash_ce_n_o)
    else $error("strobe without chip enable");
  c_read: cover property ($rose(flash_oe_n_o));
  c_write: cover property ($rose(flash_we_n_o));
  c_unmapped: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i > 3'h5);
endmodule
bind flash_ctrl flash_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .GAP_CYC(GAP_CYC)) mon (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_n_o(flash_dq_oe_n_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o));

// [test/flash_dev_model.sv]
// Behavioural flash device: program, sector erase window, status bits and ready/busy.
// Assumes strobes are synchronous to ref_clk_i; progress is counted in status reads.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int WIN = 300,
  parameter int PULSES = 3,
  parameter int ERASE_RD = 4,
  parameter logic [15:0] RST_CMD = 16'h00f0,
  parameter logic [15:0] SE_CMD = 16'h0030,
  parameter logic [15:0] CE_CMD = 16'h0010
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] dq_w_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [15:0] dq_r_o,
  output logic ready_busy_o
);
  logic [15:0] mem_q, out_q, word;
  logic we_q, oe_q, tog_q, s2_q, sel_q, fail_q, act;
  int win_q, er_q, busy_q, f_cnt_q;
  assign act = busy_q != 0 || fail_q || sel_q;
  // A released bus shows the inverse of the last word; the new word appears one cycle into the strobe.
  assign dq_r_o = (!ce_n_i && !oe_n_i) ? out_q : ~out_q;
  assign ready_busy_o = !act;
  always_comb begin
    word = mem_q;
    if (act) begin
      word = 16'h0000;
      word[6] = tog_q;
      word[5] = fail_q && f_cnt_q >= PULSES;
      word[3] = er_q != 0;
      word[2] = sel_q && s2_q;
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_q <= 16'hffff;
      out_q <= 16'h0000;
      {we_q, oe_q, tog_q, s2_q, sel_q, fail_q} <= 6'h3c;
      {win_q, er_q, busy_q, f_cnt_q} <= '0;
    end else begin
      we_q <= we_n_i;
      oe_q <= oe_n_i;
      if (win_q != 0) win_q <= win_q - 1;
      if (win_q == 1) er_q <= ERASE_RD;
      if (!we_n_i && we_q && !ce_n_i && er_q == 0) begin
        if (dq_w_i == RST_CMD) begin
          {busy_q, win_q} <= '0;
          {fail_q, sel_q} <= 2'h0;
        end else if (dq_w_i == SE_CMD) begin
          win_q <= WIN;
          sel_q <= 1'b1;
        end else if (dq_w_i == CE_CMD && win_q == 0) begin
          // Chip erase starts at once: no acceptance window, the timer flag reads one.
          er_q <= ERASE_RD;
          sel_q <= 1'b1;
        end else if (win_q == 0 && |(dq_w_i & ~mem_q)) begin
          fail_q <= 1'b1;
          f_cnt_q <= 0;
        end else if (win_q == 0) begin
          mem_q <= mem_q & dq_w_i;
          busy_q <= PULSES;
        end
      end
      if (!oe_n_i && oe_q && !ce_n_i) begin
        out_q <= word;
        if (act) tog_q <= ~tog_q;
        if (sel_q) s2_q <= ~s2_q;
        if (fail_q) f_cnt_q <= f_cnt_q + 1;
        if (busy_q != 0) busy_q <= busy_q - 1;
        if (er_q != 0) er_q <= er_q - 1;
        if (er_q == 1) begin
          sel_q <= 1'b0;
          mem_q <= 16'hffff;
        end
      end
    end
  end
endmodule

// [test/flash_ctrl_tb_top.sv]
// Self-checking bench: Avalon register accesses drive program, poll and erase orders.
// Assumes the flash model answers on the pins and the map header gives offsets.
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_ctrl_tb_top;
  localparam int WIN = 300;
  localparam logic [15:0] RST_CMD = 16'h00f0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] adr = 3'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, st;
  logic wreq, f_ce_n, f_oe_n, f_we_n, f_rb;
  logic [15:0] f_din, f_dout;
  int failures = 0;
  int num_checks = 0;
  int reads = 0;
  int rd0;
  always #2 clk = ~clk;
  always @(negedge f_oe_n) reads++;
  flash_ctrl #(.GAP_CYC(50)) uut (.ref_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .flash_addr_o(), .flash_dq_i(f_din), .flash_dq_o(f_dout),
    .flash_dq_oe_n_o(), .flash_ce_n_o(f_ce_n), .flash_oe_n_o(f_oe_n),
    .flash_we_n_o(f_we_n), .flash_ready_busy_i(f_rb));
  // An even pulse count lets toggling stop between read pairs, so polls end on array reads.
  flash_dev_model #(.WIN(WIN), .PULSES(2), .RST_CMD(RST_CMD)) dev (.ref_clk_i(clk), .rst_i(rst),
    .dq_w_i(f_dout), .ce_n_i(f_ce_n), .oe_n_i(f_oe_n), .we_n_i(f_we_n), .dq_r_o(f_din),
    .ready_busy_o(f_rb));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until waitrequest is sampled low, then released.
  task acc(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    rd_en <= !w;
    wr_en <= w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (wreq !== 1'b0) begin
      failures++;
      $display("Error at %0t: no bus answer", $time);
    end
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task rd_data(input logic [31:0] exp);
    acc(1'b0, `REG_RDATA, 32'h0, st);
    chk(st, exp);
  endtask
  task run(input flash_ctrl_pkg::op_t op, input logic [31:0] exp, input logic skip = 1'b0);
    int n;
    n = 0;
    wr(`REG_CTRL, {27'h0, skip, 2'b00, op});
    do begin
      acc(1'b0, `REG_STATUS, 32'h0, st);
      n++;
    end while (st[`ST_BUSY] !== 1'b0 && n < 3000);
    chk(st, exp);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // The tests need under two thousand cycles; this span leaves wide margin for the slow polls.
  initial begin
    #60000;
    failures++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, `REG_STATUS, 32'h0, st);
    chk(st, 32'h40);
    acc(1'b0, 3'h7, 32'h0, st);
    chk(st, 32'h0);
    wr(`REG_RSTCMD, {16'h0, RST_CMD});
    wr(`REG_ADDR, 32'h100);
    wr(`REG_WDATA, 32'ha5);
    run(flash_ctrl_pkg::OP_WRITE, 32'h02);
    run(flash_ctrl_pkg::OP_POLL, 32'h42);
    run(flash_ctrl_pkg::OP_READ, 32'h42);
    rd_data(32'ha5);
    // Setting a bit that is already cleared must end in the timing-limit failure.
    wr(`REG_WDATA, 32'hff);
    run(flash_ctrl_pkg::OP_WRITE, 32'h02);
    run(flash_ctrl_pkg::OP_POLL, 32'h44);
    run(flash_ctrl_pkg::OP_READ, 32'h42);
    rd_data(32'ha5);
    wr(`REG_WDATA, 32'h30);
    run(flash_ctrl_pkg::OP_SECT_ERASE, 32'h02);
    // Two more commands, each inside the window but together longer than it.
    // Skip is asked for, but the gap has run out, so the pre-check read must stay.
    for (int i = 0; i < 2; i++) begin
      repeat (200) @(posedge clk);
      rd0 = reads;
      run(flash_ctrl_pkg::OP_SECT_ERASE, 32'h02, 1'b1);
      chk(reads - rd0, 32'h2);
    end
    repeat (WIN + 20) @(posedge clk);
    run(flash_ctrl_pkg::OP_SECT_ERASE, 32'h10);
    run(flash_ctrl_pkg::OP_POLL, 32'h42);
    run(flash_ctrl_pkg::OP_READ, 32'h42);
    rd_data(32'hffff);
    // A chip erase shows the timer flag at once, so a sector command finds it closed.
    wr(`REG_WDATA, 32'h10);
    run(flash_ctrl_pkg::OP_WRITE, 32'h02);
    run(flash_ctrl_pkg::OP_SECT_ERASE, 32'h10);
    run(flash_ctrl_pkg::OP_POLL, 32'h42);
    finish_test;
  end
endmodule
